// file: bench/sees_host_model.sv
// Bus master model that drives the serial pins of the EEPROM block.
`default_nettype none
module sees_host_model (
  // Clock.
  input wire logic i_clock,
  // Serial data back from the block.
  input wire logic i_serial_out,
  input wire logic i_serial_out_en,
  // Serial pins.
  output logic o_chip_select,
  output logic o_serial_clock,
  output logic o_serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_chip_select = 1'b0;
    o_serial_clock = 1'b0;
    o_serial_in = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic sel(input logic v);
    o_chip_select <= v;
    hold(4);
  endtask
  // Levels last four system clocks, so the synchronisers never miss an edge.
  task automatic shift(input logic [24:0] w, input int n);
    for (int i = 24; i > 24 - n; i--) begin
      o_serial_in <= w[i];
      hold(4);
      o_serial_clock <= 1'b1;
      hold(4);
      o_serial_clock <= 1'b0;
    end
    o_serial_in <= ~w[25 - n];
  endtask
  task automatic fetch(output logic [16:0] d);
    for (int i = 16; i >= 0; i--) begin
      hold(4);
      d[i] = i_serial_out_en ? i_serial_out : 1'bx;
      if (i > 0) begin
        o_serial_clock <= 1'b1;
        hold(4);
        o_serial_clock <= 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: bench/serial_eeprom_erase_status_tb_top.sv
// Self-checking bench for the serial EEPROM command and status block.
`default_nettype none
module serial_eeprom_erase_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PROG = 40;
  typedef struct {
    logic [1:0] op;
    logic [5:0] addr;
    logic [15:0] data;
    int n;
    logic prog;
    logic [5:0] ra;
    logic [15:0] rd;
  } sees_row_t;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic cs;
  logic sck;
  logic sdi;
  logic o_serial_out;
  logic o_serial_out_en;
  int failures = 0;
  int total_checks = 0;
  sees_row_t rows [9] = '{
    '{2'h0, 6'h30, 16'h0, 9, 1'b0, 6'h0, 16'h0},
    '{2'h0, 6'h2a, 16'h0, 9, 1'b1, 6'h05, 16'hffff},
    '{2'h1, 6'h03, 16'h1234, 25, 1'b1, 6'h03, 16'h1234},
    '{2'h3, 6'h03, 16'h0, 9, 1'b1, 6'h03, 16'hffff},
    '{2'h1, 6'h3f, 16'h5a5a, 25, 1'b1, 6'h3f, 16'h5a5a},
    '{2'h3, 6'h3f, 16'h0, 10, 1'b0, 6'h3f, 16'h5a5a},
    '{2'h0, 6'h1c, 16'ha5a5, 25, 1'b1, 6'h00, 16'ha5a5},
    '{2'h0, 6'h0f, 16'h0, 9, 1'b0, 6'h3f, 16'ha5a5},
    '{2'h1, 6'h01, 16'h0, 25, 1'b0, 6'h01, 16'ha5a5}
  };
  always #50 i_clock = ~i_clock;
  sees_host_model host (
    .i_clock(i_clock),
    .i_serial_out(o_serial_out),
    .i_serial_out_en(o_serial_out_en),
    .o_chip_select(cs),
    .o_serial_clock(sck),
    .o_serial_in(sdi)
  );
  sees_core #(.PROG_CYCLES(PROG)) DUT (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_chip_select(cs),
    .i_serial_clock(sck),
    .i_serial_in(sdi),
    .o_serial_out(o_serial_out),
    .o_serial_out_en(o_serial_out_en)
  );
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic rd_check(input logic [5:0] a, input logic [15:0] e);
    logic [16:0] d;
    host.sel(1'b1);
    host.shift({3'b110, a, 16'h0}, 9);
    host.fetch(d);
    host.sel(1'b0);
    chk("read_word", e, d[15:0]);
    chk("read_dummy", 16'h0, {15'h0, d[16]});
  endtask
  // Status of a programming row is polled twice with a select drop between, as a host would.
  task automatic run_row(input sees_row_t r);
    time t0;
    host.sel(1'b1);
    host.shift({1'b1, r.op, r.addr, r.data}, r.n);
    t0 = $time;
    host.sel(1'b0);
    host.sel(1'b1);
    host.hold(8);
    chk("status_en", {15'h0, r.prog}, {15'h0, o_serial_out_en});
    if (r.prog) begin
      chk("busy_level", 16'h0, {15'h0, o_serial_out});
      host.sel(1'b0);
      host.hold(4);
      chk("float_en", 16'h0, {15'h0, o_serial_out_en});
      host.sel(1'b1);
      host.hold(8);
      for (int i = 0; i < 100 && !(o_serial_out_en === 1'b1 && o_serial_out === 1'b1); i++) begin
        host.hold(1);
      end
      chk("ready_time", 16'h1, {15'h0, ($time - t0 >= (PROG + 2) * 100 && $time - t0 <= (PROG + 9) * 100)});
      host.shift(25'h1000000, 1);
      host.hold(4);
      chk("status_cleared", 16'h0, {15'h0, o_serial_out_en});
    end
    host.sel(1'b0);
  endtask
  initial begin
    repeat (12) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    host.hold(4);
    for (int i = 0; i < 9; i++) begin
      run_row(rows[i]);
      if (i > 0) rd_check(rows[i].ra, rows[i].rd);
    end
    // A reset in mid-run must leave the block write-disabled again.
    run_row(rows[0]);
    i_sys_rst <= 1'b1;
    host.hold(12);
    chk("reset_en", 16'h0, {15'h0, o_serial_out_en});
    i_sys_rst <= 1'b0;
    host.hold(4);
    run_row(rows[8]);
    rd_check(6'h01, 16'ha5a5);
    complete_run();
  end
  initial begin
    repeat (30000) @(posedge i_clock);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire

// file: hdl/sees_core.sv
// Command decoder, self-timed programming and ready/busy status of a 64 by 16 serial EEPROM.
`default_nettype none
module sees_core #(
  parameter int unsigned PROG_CYCLES = sees_pkg::PROGRAM_CYCLES
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Serial pins from the bus master.
  input wire logic i_chip_select,
  input wire logic i_serial_clock,
  input wire logic i_serial_in,
  // Serial data out, three-state.
  output logic o_serial_out,
  output logic o_serial_out_en
);
  if (PROG_CYCLES < 1) begin : g_check
    $error("PROG_CYCLES must be at least one");
  end

  logic cs_meta, cs_sync, cs_prev;
  logic sk_meta, sk_sync, sk_prev;
  logic di_meta, di_sync;
  sees_pkg::sees_state_t state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [15:0] data_reg, data_next;
  logic [15:0] rd_reg, rd_next;
  logic wen_reg, busy_reg, status_reg, all_reg;
  logic dummy_reg;
  logic [5:0] paddr_reg;
  logic [15:0] pdata_reg;
  logic [31:0] pcnt_reg;
  logic [15:0] mem [sees_pkg::WORDS];

  // Synchronisers: the first stage is read only by the second.
  always_ff @(posedge i_clock) begin
    cs_meta <= i_chip_select;
    cs_sync <= cs_meta;
    cs_prev <= cs_sync;
    sk_meta <= i_serial_clock;
    sk_sync <= sk_meta;
    sk_prev <= sk_sync;
    di_meta <= i_serial_in;
    di_sync <= di_meta;
  end

  wire cs_fall = cs_prev & ~cs_sync;
  wire sk_rise = sk_sync & ~sk_prev & cs_sync;
  wire [1:0] op = cmd_reg[7:6];
  wire [1:0] sub = cmd_reg[5:4];
  wire [7:0] cmd_shift = {cmd_reg[6:0], di_sync};
  wire is_write = op == sees_pkg::OP_WRITE;
  wire is_erase = op == sees_pkg::OP_ERASE;
  wire is_ctrl = op == sees_pkg::OP_CTRL;
  wire is_wen = is_ctrl & (sub == sees_pkg::SUB_WRITE_ENABLE);
  wire is_wds = is_ctrl & (sub == sees_pkg::SUB_WRITE_DISABLE);
  wire is_wral = is_ctrl & (sub == sees_pkg::SUB_WRITE_ALL);
  wire is_erase_all_cmd = is_ctrl & (sub == sees_pkg::SUB_ERASE_ALL);
  wire needs_data = (cmd_shift[7:6] == sees_pkg::OP_WRITE) ||
    (cmd_shift[7:4] == {sees_pkg::OP_CTRL, sees_pkg::SUB_WRITE_ALL});
  // A program command counts only when it ended exactly on its last bit.
  wire execute = cs_fall & (state_reg == sees_pkg::S_DONE);
  wire prog_cmd = is_write | is_erase | is_wral | is_erase_all_cmd;
  wire prog_start = execute & prog_cmd & wen_reg & ~busy_reg;
  wire prog_end = busy_reg & (pcnt_reg == 32'h0);
  // Status is cleared by a start bit once ready; this same bit opens the command.
  wire start_bit = sk_rise & di_sync & (state_reg == sees_pkg::S_IDLE) & ~busy_reg;
  wire [15:0] mem_rd = mem[cmd_shift[5:0]];

  // Command shifter; all serial activity is ignored while programming runs.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    data_next = data_reg;
    rd_next = rd_reg;
    if (!cs_sync || busy_reg) begin
      state_next = sees_pkg::S_IDLE;
    end else if (sk_rise) begin
      case (state_reg)
        sees_pkg::S_IDLE: begin
          if (di_sync) begin
            state_next = sees_pkg::S_CMD;
            cnt_next = 5'h00;
          end
        end
        sees_pkg::S_CMD: begin
          cmd_next = cmd_shift;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == sees_pkg::CMD_LAST) begin
            cnt_next = 5'h00;
            if (cmd_shift[7:6] == sees_pkg::OP_READ) begin
              state_next = sees_pkg::S_READ;
              rd_next = mem_rd;
            end else if (needs_data) begin
              state_next = sees_pkg::S_DATA;
            end else begin
              state_next = sees_pkg::S_DONE;
            end
          end
        end
        sees_pkg::S_DATA: begin
          data_next = {data_reg[14:0], di_sync};
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == sees_pkg::DATA_LAST) begin
            state_next = sees_pkg::S_DONE;
          end
        end
        sees_pkg::S_READ: begin
          rd_next = dummy_reg ? rd_reg : {rd_reg[14:0], 1'b0};
        end
        sees_pkg::S_DONE: begin
          state_next = sees_pkg::S_OVER;
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  // The read path leads with a zero bit, then shifts the word out most significant first.
  wire read_first = (state_reg == sees_pkg::S_CMD) & (state_next == sees_pkg::S_READ);
  // The zero bit stands until the next serial clock rise, so the host sees it for a whole bit time.
  wire dummy_next = read_first | (dummy_reg & (state_next == sees_pkg::S_READ) & ~sk_rise);
  wire do_en_next = cs_sync & (status_reg | (state_next == sees_pkg::S_READ));
  wire do_next = status_reg ? ~busy_reg : ((read_first | dummy_reg) ? 1'b0 : rd_reg[15]);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_reg <= sees_pkg::S_IDLE;
      cnt_reg <= 5'h00;
      cmd_reg <= 8'h00;
      data_reg <= 16'h0000;
      rd_reg <= 16'h0000;
      dummy_reg <= 1'b0;
      o_serial_out <= 1'b0;
      o_serial_out_en <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      data_reg <= data_next;
      rd_reg <= (sk_rise && state_reg == sees_pkg::S_READ) ? rd_next :
        (read_first ? rd_next : rd_reg);
      dummy_reg <= dummy_next;
      o_serial_out <= do_next;
      o_serial_out_en <= do_en_next;
    end
  end

  // Write enable latch, taken on the select falling edge of a complete command.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wen_reg <= 1'b0;
    end else if (execute && !busy_reg && is_wen) begin
      wen_reg <= 1'b1;
    end else if (execute && !busy_reg && is_wds) begin
      wen_reg <= 1'b0;
    end
  end

  // Self-timed programming; the counter stands in for the programming time.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      busy_reg <= 1'b0;
      status_reg <= 1'b0;
      all_reg <= 1'b0;
      paddr_reg <= 6'h00;
      pdata_reg <= 16'h0000;
      pcnt_reg <= 32'h0;
    end else begin
      if (prog_start) begin
        busy_reg <= 1'b1;
        status_reg <= 1'b1;
        all_reg <= is_wral | is_erase_all_cmd;
        paddr_reg <= cmd_reg[5:0];
        pdata_reg <= (is_erase || is_erase_all_cmd) ? sees_pkg::ERASED_WORD : data_reg;
        pcnt_reg <= PROG_CYCLES - 32'h1;
      end else if (busy_reg) begin
        pcnt_reg <= pcnt_reg - 32'h1;
        if (prog_end) begin
          busy_reg <= 1'b0;
        end
      end else if (start_bit) begin
        status_reg <= 1'b0;
      end
    end
  end

  // Array update at the end of the programming time; the stored words survive reset.
  always_ff @(posedge i_clock) begin
    for (int i = 0; i < sees_pkg::WORDS; i++) begin
      if (prog_end && (all_reg || paddr_reg == 6'(i))) begin
        mem[i] <= pdata_reg;
      end
    end
  end

  a_do_float_low: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !cs_sync |=> !o_serial_out_en)
    else $error("data out driven while select low");
  a_erase_word_ones: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    prog_end && !all_reg && pdata_reg == sees_pkg::ERASED_WORD |=> mem[paddr_reg] == 16'hffff)
    else $error("erased word not all ones");
  a_erase_all_ones: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    prog_end && all_reg && pdata_reg == sees_pkg::ERASED_WORD |=> mem[0] == 16'hffff && mem[63] == 16'hffff)
    else $error("erase all left a word not all ones");
  a_start_on_fall: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $rose(busy_reg) |-> $past(cs_fall) && $past(state_reg) == sees_pkg::S_DONE)
    else $error("programming started without select falling edge");
  a_busy_holds: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    busy_reg && pcnt_reg != 32'h0 |=> busy_reg)
    else $error("busy dropped before programming time ended");
  a_select_toggle_safe: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    busy_reg && pcnt_reg != 32'h0 && (cs_fall || sk_rise) |=> busy_reg && $past(pcnt_reg) - 32'h1 == pcnt_reg)
    else $error("select activity disturbed programming");
  a_busy_shows_low: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    cs_sync && status_reg && busy_reg && !prog_end ##1 busy_reg |-> o_serial_out_en && !o_serial_out)
    else $error("busy not shown as low");
  a_ready_shows_high: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    cs_sync && status_reg && !busy_reg && !start_bit |=> o_serial_out_en && o_serial_out)
    else $error("ready not shown as high");
  a_start_clears: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    status_reg && start_bit |=> !status_reg ##1 !o_serial_out_en)
    else $error("start bit did not clear ready status");
  a_enable_gates: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $rose(busy_reg) |-> $past(wen_reg))
    else $error("programming without write enable");
  a_ctrl_decode: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    execute && !busy_reg && is_wds |=> !wen_reg)
    else $error("write disable not decoded");
endmodule
`default_nettype wire

// file: hdl/sees_pkg.sv
// Package with the constants and types of the serial EEPROM command and status block.
`default_nettype none
package sees_pkg;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned ADDR_BITS = 6;
  localparam int unsigned WORDS = 64;
  localparam int unsigned CMD_BITS = 8;
  // Bit counts within a field after the start bit, minus one, at which the field is complete.
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [1:0] OP_CTRL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // Upper two address bits that select a control command.
  localparam logic [1:0] SUB_WRITE_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_WRITE_ENABLE = 2'h3;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [15:0] RESET_WORD = 16'hffff;
  localparam int unsigned CLOCK_PERIOD_NS = 100;
  localparam int unsigned PROGRAM_CYCLE_TIME_NS = 10000000;
  localparam int unsigned PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_NS / CLOCK_PERIOD_NS;
  typedef enum logic [2:0] {
    S_IDLE,
    S_CMD,
    S_DATA,
    S_READ,
    S_DONE,
    S_OVER
  } sees_state_t;
endpackage
`default_nettype wire
